// *** inc/gfm_pkg.sv ***
`default_nettype none
package gfm_pkg;
   localparam int GFM_PINS = 8;
   localparam int GFM_AW = 12;
   localparam int GFM_SYNC_STAGES = 2;
   // register indices; byte address is four times the index
   localparam logic [9:0] GFM_IDX_DIR = 10'h06e;
   localparam logic [9:0] GFM_IDX_ISEL2 = 10'h06f;
   localparam logic [9:0] GFM_IDX_ISEL1 = 10'h070;
   localparam logic [9:0] GFM_IDX_ISEL0 = 10'h071;
   localparam logic [9:0] GFM_IDX_OSEL2 = 10'h072;
   localparam logic [9:0] GFM_IDX_OSEL1 = 10'h073;
   localparam logic [9:0] GFM_IDX_OSEL0 = 10'h074;
   localparam logic [9:0] GFM_IDX_RSVD = 10'h075;
   localparam logic [9:0] GFM_IDX_GPO = 10'h076;
   localparam logic [9:0] GFM_IDX_GPI = 10'h219;
   localparam logic [11:0] GFM_ADDR_DIR = {GFM_IDX_DIR, 2'b00};
   localparam logic [11:0] GFM_ADDR_ISEL2 = {GFM_IDX_ISEL2, 2'b00};
   localparam logic [11:0] GFM_ADDR_ISEL1 = {GFM_IDX_ISEL1, 2'b00};
   localparam logic [11:0] GFM_ADDR_ISEL0 = {GFM_IDX_ISEL0, 2'b00};
   localparam logic [11:0] GFM_ADDR_OSEL2 = {GFM_IDX_OSEL2, 2'b00};
   localparam logic [11:0] GFM_ADDR_OSEL1 = {GFM_IDX_OSEL1, 2'b00};
   localparam logic [11:0] GFM_ADDR_OSEL0 = {GFM_IDX_OSEL0, 2'b00};
   localparam logic [11:0] GFM_ADDR_RSVD = {GFM_IDX_RSVD, 2'b00};
   localparam logic [11:0] GFM_ADDR_GPO = {GFM_IDX_GPO, 2'b00};
   localparam logic [11:0] GFM_ADDR_GPI = {GFM_IDX_GPI, 2'b00};
   // function selector codes
   localparam logic [2:0] GFM_FN_PLAIN = 3'h0;
   localparam logic [2:0] GFM_FN_OE = 3'h1;
   localparam logic [2:0] GFM_FN_REFSEL = 3'h5;
   localparam logic [2:0] GFM_FN_ALT_A = 3'h1;
   localparam logic [2:0] GFM_FN_ALT_B = 3'h2;
   // pins carrying the manual reference-select bits
   localparam int GFM_REF0_B0_PIN = 2;
   localparam int GFM_REF1_B0_PIN = 3;
   localparam int GFM_REF0_B1_PIN = 6;
   localparam int GFM_REF1_B1_PIN = 7;
   // reset values
   localparam logic [7:0] GFM_DIR_RST = 8'h00;
   localparam logic [7:0] GFM_SEL_RST = 8'h00;
   localparam logic [7:0] GFM_GPO_RST = 8'h00;
   localparam logic [1:0] GFM_WARM_MAX = 2'h3;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [GFM_AW-1:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } gfm_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } gfm_apb_rsp_type;

   typedef struct packed {
      logic [1:0] pll_loss_of_lock;
      logic [1:0] pll_holdover;
      logic [3:0] ref_loss_of_signal;
   } gfm_status_type;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] isel2;
      logic [7:0] isel1;
      logic [7:0] isel0;
      logic [7:0] osel2;
      logic [7:0] osel1;
      logic [7:0] osel0;
      logic [7:0] pin_output_value;
      logic [7:0] in_val;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] ck_oe;
      logic [7:0] ck_oe_act;
      logic [1:0] ref0;
      logic [1:0] ref1;
      logic [1:0] ref0_act;
      logic [1:0] ref1_act;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [1:0] warm;
   } gfm_state_type;

   localparam gfm_state_type GFM_STATE_RST = '{
      dir: GFM_DIR_RST,
      isel2: GFM_SEL_RST,
      isel1: GFM_SEL_RST,
      isel0: GFM_SEL_RST,
      osel2: GFM_SEL_RST,
      osel1: GFM_SEL_RST,
      osel0: GFM_SEL_RST,
      pin_output_value: GFM_GPO_RST,
      default: '0
   };
endpackage
`default_nettype wire

// *** hw/gfm_sync.sv ***
`default_nettype none
module gfm_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } gfm_sync_state_type;

   gfm_sync_state_type st_r;
   gfm_sync_state_type st_nxt;

   // first stage feeds only the second stage
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule
`default_nettype wire

// *** hw/gfm_top.sv ***
// Local design decision: register access over APB.
`default_nettype none
module gfm_top
   import gfm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire gfm_apb_req_type apb_req,
   output var gfm_apb_rsp_type apb_rsp,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   input wire gfm_status_type status,
   output logic [7:0] clock_output_enable,
   output logic [7:0] clock_output_enable_active,
   output logic [1:0] manual_ref_select_pll_zero,
   output logic [1:0] manual_ref_select_pll_one,
   output logic [1:0] manual_ref_select_pll_zero_active,
   output logic [1:0] manual_ref_select_pll_one_active
);
   gfm_state_type st_r;
   gfm_state_type st_nxt;
   logic [7:0] pin_q;
   logic [7:0] plain_mask;
   logic [7:0] oe_mask;
   logic [7:0] refsel_mask;
   logic [7:0] out_bit;
   logic [11:0] addr;
   logic setup;
   logic wr_acc;

   // pins come from the board, asynchronous to pclk
   gfm_sync #(
      .W(GFM_PINS)
   ) gfm_sync_inst (
      .clk(pclk),
      .rst_n(presetn),
      .d(pin_in),
      .q(pin_q)
   );

   // three selector planes hold one bit of each pin's code
   function automatic logic [2:0] sel_code(
      input logic [7:0] b2,
      input logic [7:0] b1,
      input logic [7:0] b0,
      input int n
   );
      return {b2[n], b1[n], b0[n]};
   endfunction

   // map check shared by error flag and the unmapped-access assertion
   function automatic logic reg_hit(input logic [11:0] a);
      logic h;
      h = 1'b0;
      case (a)
         GFM_ADDR_DIR, GFM_ADDR_ISEL2, GFM_ADDR_ISEL1, GFM_ADDR_ISEL0,
         GFM_ADDR_OSEL2, GFM_ADDR_OSEL1, GFM_ADDR_OSEL0, GFM_ADDR_RSVD,
         GFM_ADDR_GPO, GFM_ADDR_GPI: begin
            h = 1'b1;
         end
         default: begin
            h = 1'b0;
         end
      endcase
      return h;
   endfunction

   // read mux; the reserved slot reads zero
   function automatic logic [7:0] rd_mux(input gfm_state_type s, input logic [11:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         GFM_ADDR_DIR: begin
            v = s.dir;
         end
         GFM_ADDR_ISEL2: begin
            v = s.isel2;
         end
         GFM_ADDR_ISEL1: begin
            v = s.isel1;
         end
         GFM_ADDR_ISEL0: begin
            v = s.isel0;
         end
         GFM_ADDR_OSEL2: begin
            v = s.osel2;
         end
         GFM_ADDR_OSEL1: begin
            v = s.osel1;
         end
         GFM_ADDR_OSEL0: begin
            v = s.osel0;
         end
         GFM_ADDR_GPO: begin
            v = s.pin_output_value;
         end
         GFM_ADDR_GPI: begin
            v = s.in_val;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   // per-pin output function; reserved codes drive low
   function automatic logic out_func(
      input int n,
      input logic [2:0] c,
      input logic pin_output_value,
      input gfm_status_type s
   );
      logic v;
      v = 1'b0;
      if (c == GFM_FN_PLAIN) begin
         v = pin_output_value;
      end else begin
         case (n)
            0: begin
               if (c == GFM_FN_ALT_A) v = s.pll_loss_of_lock[0];
               if (c == GFM_FN_ALT_B) v = s.pll_loss_of_lock[1];
            end
            1: begin
               if (c == GFM_FN_ALT_A) v = s.pll_holdover[0];
               if (c == GFM_FN_ALT_B) v = s.pll_holdover[1];
            end
            2: begin
               if (c == GFM_FN_ALT_A) v = s.ref_loss_of_signal[0];
            end
            3: begin
               if (c == GFM_FN_ALT_A) v = s.pll_loss_of_lock[1];
               if (c == GFM_FN_ALT_B) v = s.ref_loss_of_signal[1];
            end
            4: begin
               if (c == GFM_FN_ALT_A) v = s.pll_holdover[1];
            end
            5: begin
               if (c == GFM_FN_ALT_A) v = s.ref_loss_of_signal[1];
            end
            6: begin
               if (c == GFM_FN_ALT_A) v = s.ref_loss_of_signal[2];
            end
            7: begin
               if (c == GFM_FN_ALT_A) v = s.ref_loss_of_signal[3];
            end
            default: begin
               v = 1'b0;
            end
         endcase
      end
      return v;
   endfunction

   // per-pin decode of direction and both selectors
   for (genvar g = 0; g < GFM_PINS; g++) begin : g_pin
      logic [2:0] ic;
      logic [2:0] oc;
      logic ref_pin;
      assign ic = sel_code(st_r.isel2, st_r.isel1, st_r.isel0, g);
      assign oc = sel_code(st_r.osel2, st_r.osel1, st_r.osel0, g);
      assign ref_pin = (g == GFM_REF0_B0_PIN) || (g == GFM_REF1_B0_PIN) ||
                       (g == GFM_REF0_B1_PIN) || (g == GFM_REF1_B1_PIN);
      assign plain_mask[g] = !st_r.dir[g] && (ic == GFM_FN_PLAIN);
      assign oe_mask[g] = !st_r.dir[g] && (ic == GFM_FN_OE);
      assign refsel_mask[g] = !st_r.dir[g] && (ic == GFM_FN_REFSEL) && ref_pin;
      assign out_bit[g] = st_r.dir[g] && out_func(g, oc, st_r.pin_output_value[g], status);
   end

   assign addr = apb_req.paddr;
   assign setup = apb_req.psel && !apb_req.penable;
   assign wr_acc = apb_req.psel && apb_req.penable && st_r.pready && apb_req.pwrite;

   // all next state in one place
   always_comb begin
      st_nxt = st_r;
      // pin side, registered so every output is a flop
      st_nxt.in_val = pin_q & plain_mask;
      st_nxt.pin_out = out_bit;
      st_nxt.pin_oe = st_r.dir;
      st_nxt.ck_oe = pin_q & oe_mask;
      st_nxt.ck_oe_act = oe_mask;
      st_nxt.ref0 = {pin_q[GFM_REF0_B1_PIN] & refsel_mask[GFM_REF0_B1_PIN],
                     pin_q[GFM_REF0_B0_PIN] & refsel_mask[GFM_REF0_B0_PIN]};
      st_nxt.ref1 = {pin_q[GFM_REF1_B1_PIN] & refsel_mask[GFM_REF1_B1_PIN],
                     pin_q[GFM_REF1_B0_PIN] & refsel_mask[GFM_REF1_B0_PIN]};
      st_nxt.ref0_act = {refsel_mask[GFM_REF0_B1_PIN], refsel_mask[GFM_REF0_B0_PIN]};
      st_nxt.ref1_act = {refsel_mask[GFM_REF1_B1_PIN], refsel_mask[GFM_REF1_B0_PIN]};
      // zero-wait slave: answer is ready in the first access cycle
      st_nxt.pready = setup;
      st_nxt.pslverr = setup && !reg_hit(addr);
      st_nxt.prdata = 32'h0000_0000;
      if (setup && !apb_req.pwrite) begin
         st_nxt.prdata = {24'h00_0000, rd_mux(st_r, addr)};
      end
      // writes land only on the completing access edge, low lane only
      if (wr_acc && apb_req.pstrb[0]) begin
         case (addr)
            GFM_ADDR_DIR: begin
               st_nxt.dir = apb_req.pwdata[7:0];
            end
            GFM_ADDR_ISEL2: begin
               st_nxt.isel2 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_ISEL1: begin
               st_nxt.isel1 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_ISEL0: begin
               st_nxt.isel0 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_OSEL2: begin
               st_nxt.osel2 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_OSEL1: begin
               st_nxt.osel1 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_OSEL0: begin
               st_nxt.osel0 = apb_req.pwdata[7:0];
            end
            GFM_ADDR_GPO: begin
               st_nxt.pin_output_value = apb_req.pwdata[7:0];
            end
            default: begin
               // read-only, reserved or unmapped: nothing stored
            end
         endcase
      end
      // settles after the synchroniser has filled
      if (st_r.warm != GFM_WARM_MAX) begin
         st_nxt.warm = st_r.warm + 2'h1;
      end
   end

   // selectors and output values reset to code zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= GFM_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops
   assign apb_rsp.prdata = st_r.prdata;
   assign apb_rsp.pready = st_r.pready;
   assign apb_rsp.pslverr = st_r.pslverr;
   assign pin_out = st_r.pin_out;
   assign pin_oe = st_r.pin_oe;
   assign clock_output_enable = st_r.ck_oe;
   assign clock_output_enable_active = st_r.ck_oe_act;
   assign manual_ref_select_pll_zero = st_r.ref0;
   assign manual_ref_select_pll_one = st_r.ref1;
   assign manual_ref_select_pll_zero_active = st_r.ref0_act;
   assign manual_ref_select_pll_one_active = st_r.ref1_act;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup_rd(logic [11:0] a);
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == a;
   endsequence

   sequence s_wr_done(logic [11:0] a);
      apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
      apb_req.paddr == a && apb_req.pstrb[0];
   endsequence

   a_dir_to_drive: assert property (s_wr_done(GFM_ADDR_DIR) |=> ##1 pin_oe == $past(apb_req.pwdata[7:0], 2))
      else $error("direction write did not reach the pin enables");

   a_input_not_driven: assert property ((pin_oe & ~$past(st_r.dir)) == 8'h00 && (pin_out & ~pin_oe) == 8'h00)
      else $error("input-mode pin is driven");

   a_sel_mode_gate: assert property ((clock_output_enable_active & $past(st_r.dir)) == 8'h00)
      else $error("input function active on an output pin");

   a_plain_in_value: assert property (st_r.warm == GFM_WARM_MAX |->
      st_r.in_val == ($past(pin_in, 3) & $past(plain_mask)))
      else $error("plain input level not in value register");

   a_gpi_read_back: assert property (s_setup_rd(GFM_ADDR_GPI) |=>
      apb_rsp.pready && !apb_rsp.pslverr && apb_rsp.prdata == {24'h00_0000, $past(st_r.in_val)})
      else $error("input value read returned wrong data");

   a_clk_oe_level: assert property (st_r.warm == GFM_WARM_MAX |->
      clock_output_enable == ($past(pin_in, 3) & $past(oe_mask)))
      else $error("clock output enable does not follow its pin");

   a_ref_sel_bits: assert property (st_r.warm == GFM_WARM_MAX |->
      manual_ref_select_pll_zero == {$past(pin_in[6], 3) & $past(refsel_mask[6]),
                                     $past(pin_in[2], 3) & $past(refsel_mask[2])} &&
      manual_ref_select_pll_one == {$past(pin_in[7], 3) & $past(refsel_mask[7]),
                                    $past(pin_in[3], 3) & $past(refsel_mask[3])})
      else $error("manual reference select bits wrong");

   a_gpo_drive: assert property (s_wr_done(GFM_ADDR_GPO) ##1 (st_r.dir[0] && st_r.osel0[0] == 1'b0 &&
      st_r.osel1[0] == 1'b0 && st_r.osel2[0] == 1'b0) |=> pin_out[0] == $past(st_r.pin_output_value[0]))
      else $error("output value bit not driven on pin 0");

   a_pin0_lol_flag: assert property ($past(st_r.dir[0]) && $past(g_pin[0].oc) == GFM_FN_ALT_B |->
      pin_out[0] == $past(status.pll_loss_of_lock[1]))
      else $error("pin 0 does not show PLL1 loss of lock");

   a_unmapped_err: assert property (apb_req.psel && !apb_req.penable && !reg_hit(apb_req.paddr) |=>
      apb_rsp.pready && apb_rsp.pslverr ##1 !apb_rsp.pready)
      else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// *** dv/gfm_board.sv ***
`default_nettype none
module gfm_board (
   input wire logic [7:0] board_val,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // wire level: the board backs off wherever the device drives, so no contention
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
   end
endmodule
`default_nettype wire

// *** dv/gpio_function_mux_tb.sv ***
`default_nettype none
module gpio_function_mux_tb;
   import gfm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   gfm_apb_req_type apb_req = '0;
   gfm_apb_rsp_type apb_rsp;
   gfm_status_type status = '0;
   logic [7:0] pin_in, pin_out, pin_oe, coe, coe_act, old_v;
   logic [7:0] board_val = 8'h00;
   logic [1:0] rs0, rs1, rs0a, rs1a;
   logic [31:0] rv;
   logic ev;
   logic [7:0] m_dir = 8'h00;
   logic [7:0] m_gpo = 8'h00;
   int m_isel[8];
   int m_osel[8];
   int cs[8];
   int fails = 0;
   int total_checks = 0;
   logic [11:0] ra[9] = '{GFM_ADDR_DIR, GFM_ADDR_ISEL2, GFM_ADDR_ISEL1, GFM_ADDR_ISEL0, GFM_ADDR_OSEL2,
                          GFM_ADDR_OSEL1, GFM_ADDR_OSEL0, GFM_ADDR_RSVD, GFM_ADDR_GPO};

   always #5 pclk = ~pclk;

   gfm_top gfm_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .status(status),
      .clock_output_enable(coe), .clock_output_enable_active(coe_act),
      .manual_ref_select_pll_zero(rs0), .manual_ref_select_pll_one(rs1),
      .manual_ref_select_pll_zero_active(rs0a), .manual_ref_select_pll_one_active(rs1a));

   gfm_board gfm_board_inst (.board_val(board_val), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // one apb transfer; request stands until pready is seen high at a rising edge
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // no assumed latency; only the watchdog ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      rv = apb_rsp.prdata;
      ev = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   // three bit planes, highest plane at the lowest address
   // planes are cleared high first and set low first, so no pin ever holds a reserved code
   task automatic set_sel(input bit outp, input int c[8]);
      logic [7:0] pl;
      logic [11:0] base;
      base = outp ? GFM_ADDR_OSEL2 : GFM_ADDR_ISEL2;
      for (int b = 2; b >= 0; b--) apb(1'b1, base + 12'((2 - b) * 4), 32'h0, 4'hf);
      for (int b = 0; b <= 2; b++) begin
         for (int p = 0; p < 8; p++) pl[p] = c[p][b];
         apb(1'b1, base + 12'((2 - b) * 4), {24'h0, pl}, 4'hf);
      end
      if (outp) m_osel = c;
      else m_isel = c;
   endtask

   function automatic logic flag(int p, int c);
      if (c == 0) return m_gpo[p];
      case (p)
         0: return c == 1 ? status.pll_loss_of_lock[0] : status.pll_loss_of_lock[1];
         1: return c == 1 ? status.pll_holdover[0] : status.pll_holdover[1];
         2: return status.ref_loss_of_signal[0];
         3: return c == 1 ? status.pll_loss_of_lock[1] : status.ref_loss_of_signal[1];
         4: return status.pll_holdover[1];
         5: return status.ref_loss_of_signal[1];
         6: return status.ref_loss_of_signal[2];
         default: return status.ref_loss_of_signal[3];
      endcase
   endfunction

   // model of every pin-side output, compared once the synchronisers have settled
   task automatic check_all();
      logic [7:0] eo, eg, ea;
      logic [7:0] sl;
      // look between edges, where every flop output has settled
      @(negedge pclk);
      for (int p = 0; p < 8; p++) begin
         eo[p] = m_dir[p] ? flag(p, m_osel[p]) : 1'b0;
         eg[p] = (!m_dir[p] && m_isel[p] == 0) ? board_val[p] : 1'b0;
         ea[p] = !m_dir[p] && m_isel[p] == 1;
         sl[p] = !m_dir[p] && m_isel[p] == 5;
      end
      chk({24'h0, pin_oe}, {24'h0, m_dir});
      chk({24'h0, pin_out}, {24'h0, eo});
      chk({24'h0, coe_act}, {24'h0, ea});
      chk({24'h0, coe}, {24'h0, ea & board_val});
      chk({28'h0, rs0a, rs1a}, {28'h0, sl[6], sl[2], sl[7], sl[3]});
      chk({28'h0, rs0, rs1}, {28'h0, sl[6] & board_val[6], sl[2] & board_val[2],
          sl[7] & board_val[7], sl[3] & board_val[3]});
      apb(1'b0, GFM_ADDR_GPI, 32'h0, 4'h0);
      chk(rv, {24'h0, eg});
   endtask

   // whole run is a few thousand cycles; this leaves about three times that
   initial begin
      #100000;
      fails++;
      finish_test();
   end

   initial begin
      void'($urandom(32'hfdf18d9f));
      for (int p = 0; p < 8; p++) begin
         m_isel[p] = 0;
         m_osel[p] = 0;
      end
      board_val <= 8'($urandom);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // every register but the input value reads back its cleared value
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0, 4'h0);
         chk(rv, 32'h0);
         chk({31'h0, ev}, 32'h0);
      end
      repeat (4) @(posedge pclk);
      check_all();
      // holes in the map and a misaligned word answer with an error and no data
      apb(1'b0, 12'h1b9, 32'h0, 4'h0);
      chk({31'h0, ev}, 32'h1);
      chk(rv, 32'h0);
      apb(1'b1, 12'h000, 32'hff, 4'hf);
      chk({31'h0, ev}, 32'h1);
      // read-only input value swallows writes; the reserved slot only ever gets zero
      apb(1'b1, GFM_ADDR_GPI, {24'h0, ~board_val}, 4'hf);
      apb(1'b1, GFM_ADDR_RSVD, 32'h0, 4'hf);
      apb(1'b0, GFM_ADDR_RSVD, 32'h0, 4'h0);
      chk(rv, 32'h0);
      chk({31'h0, ev}, 32'h0);
      // a write with its byte lane off leaves the direction alone
      apb(1'b1, GFM_ADDR_DIR, 32'hff, 4'h0);
      check_all();
      // pin change reaches the enables only after the two-stage synchroniser
      for (int p = 0; p < 8; p++) cs[p] = 1;
      set_sel(1'b0, cs);
      repeat (4) @(posedge pclk);
      old_v = board_val;
      board_val <= ~old_v;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({24'h0, coe}, {24'h0, old_v});
      @(negedge pclk);
      chk({24'h0, coe}, {24'h0, ~old_v});
      // random legal configurations; reserved codes are never programmed
      for (int it = 0; it < 60; it++) begin
         for (int p = 0; p < 8; p++) begin
            cs[p] = $urandom_range(0, 2);
            if (cs[p] == 2) cs[p] = (p == 2 || p == 3 || p == 6 || p == 7) ? 5 : 0;
         end
         set_sel(1'b0, cs);
         for (int p = 0; p < 8; p++) begin
            cs[p] = $urandom_range(0, 2);
            if (cs[p] == 2 && !(p == 0 || p == 1 || p == 3)) cs[p] = 1;
         end
         set_sel(1'b1, cs);
         m_dir = 8'($urandom);
         m_gpo = 8'($urandom);
         apb(1'b1, GFM_ADDR_DIR, {24'h0, m_dir}, 4'hf);
         apb(1'b1, GFM_ADDR_GPO, {24'h0, m_gpo}, 4'hf);
         apb(1'b0, GFM_ADDR_GPO, 32'h0, 4'h0);
         chk(rv, {24'h0, m_gpo});
         @(posedge pclk);
         status <= gfm_status_type'(8'($urandom));
         board_val <= 8'($urandom);
         repeat (4) @(posedge pclk);
         check_all();
      end
      finish_test();
   end
endmodule
`default_nettype wire
